// ---- design/cmvd_cond_eval.sv ----
`timescale 1ns/100ps
module cmvd_cond_eval
  import cmvd_pkg::*;
(
  // condition and flags
  input  wire cmvd_pkg::cmvd_cond_t cond,
  input  wire logic                 flag_c,
  input  wire logic                 flag_z,
  input  wire logic                 flag_s,
  input  wire logic                 flag_o,
  // result
  output logic                      holds
);
  import cmvd_pkg::*;

  logic lt;
  assign lt = flag_s ^ flag_o;
  always_comb begin
    case (cond)
      CMVD_C_AE: holds = ~flag_c;
      CMVD_C_B:  holds = flag_c;
      CMVD_C_E:  holds = flag_z;
      CMVD_C_NE: holds = ~flag_z;
      CMVD_C_L:  holds = lt;
      CMVD_C_LE: holds = flag_z | lt;
      CMVD_C_G:  holds = ~(flag_z | lt);
      CMVD_C_GE: holds = ~lt;
      default:   holds = 1'b0;
    endcase
  end
endmodule

// ---- design/cmvd_decode.sv ----
`timescale 1ns/100ps
module cmvd_decode
  import cmvd_pkg::*;
#(
  parameter int DATA_W = CMVD_DATA_W,
  parameter int NREG   = CMVD_NREG
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // instruction issue
  input  wire logic                          issue_valid,
  input  wire logic [7:0]                    op_escape,
  input  wire logic [7:0]                    op_code,
  input  wire logic [7:0]                    op_modrm,
  // memory operand, already fetched on a cache hit
  input  wire logic [DATA_W-1:0]             mem_data,
  // flags in
  input  wire logic                          flag_c,
  input  wire logic                          flag_z,
  input  wire logic                          flag_s,
  input  wire logic                          flag_o,
  // register file read port
  output logic [DATA_W-1:0]                  gpr_rd_data,
  input  wire logic [CMVD_RSEL_W-1:0]        gpr_rd_sel,
  // status
  output logic                               is_cmov,
  output logic                               done_r,
  output logic                               moved_r,
  output logic                               flags_we
);
  import cmvd_pkg::*;

  logic [DATA_W-1:0]      gpr_r [NREG];
  cmvd_cond_t             cond;
  logic                   holds;
  logic [1:0]             f_mod;
  logic [CMVD_RSEL_W-1:0] f_reg;
  logic [CMVD_RSEL_W-1:0] f_rm;
  logic [DATA_W-1:0]      src;
  logic                   do_move;

  function automatic cmvd_cond_t cmvd_map(input logic [7:0] esc, input logic [7:0] op);
    cmvd_map = CMVD_C_NONE;
    if (esc == CMVD_ESCAPE) begin
      case (op)
        CMVD_OP_AE: cmvd_map = CMVD_C_AE;
        CMVD_OP_B:  cmvd_map = CMVD_C_B;
        CMVD_OP_E:  cmvd_map = CMVD_C_E;
        CMVD_OP_NE: cmvd_map = CMVD_C_NE;
        CMVD_OP_G:  cmvd_map = CMVD_C_G;
        CMVD_OP_LE: cmvd_map = CMVD_C_LE;
        CMVD_OP_L:  cmvd_map = CMVD_C_L;
        CMVD_OP_GE: cmvd_map = CMVD_C_GE;
        default:    cmvd_map = CMVD_C_NONE;
      endcase
    end
  endfunction

  assign cond    = cmvd_map(op_escape, op_code);
  assign is_cmov = issue_valid && (cond != CMVD_C_NONE);
  // operand specifier fields
  assign f_mod   = op_modrm[CMVD_MOD_HI:CMVD_MOD_LO];
  assign f_reg   = op_modrm[CMVD_REG_HI:CMVD_REG_LO];
  assign f_rm    = op_modrm[CMVD_RM_HI:CMVD_RM_LO];
  assign src     = (f_mod == CMVD_MOD_REG) ? gpr_r[f_rm] : mem_data;
  // flags never written by this family
  assign flags_we = 1'b0;

  cmvd_cond_eval u_eval (
    .cond   (cond),
    .flag_c (flag_c),
    .flag_z (flag_z),
    .flag_s (flag_s),
    .flag_o (flag_o),
    .holds  (holds)
  );

  assign do_move = is_cmov && holds;
  assign gpr_rd_data = gpr_r[gpr_rd_sel];

  // register file write, single cycle
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_gpr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          gpr_r[gi] <= '0;
        end else if (do_move && (f_reg == CMVD_RSEL_W'(gi))) begin
          gpr_r[gi] <= src;
        end
      end
      property p_others;
        @(posedge clk) disable iff (!rst_n)
          !(do_move && f_reg == CMVD_RSEL_W'(gi)) |=> $stable(gpr_r[gi]);
      endproperty
      a_others: assert property (p_others) else $error("stray register write");
    end
  endgenerate

  // completion status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r  <= 1'b0;
      moved_r <= 1'b0;
    end else begin
      done_r  <= is_cmov;
      moved_r <= do_move;
    end
  end

  property p_done_one;
    @(posedge clk) disable iff (!rst_n) is_cmov |=> done_r;
  endproperty
  a_done_one: assert property (p_done_one) else $error("cmov not done in one clock");

  property p_write_src;
    @(posedge clk) disable iff (!rst_n)
      do_move |=> gpr_r[$past(f_reg)] == $past(src);
  endproperty
  a_write_src: assert property (p_write_src) else $error("destination not loaded");

  property p_keep;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && !holds) |=> gpr_r[$past(f_reg)] == $past(gpr_r[f_reg]);
  endproperty
  a_keep: assert property (p_keep) else $error("destination changed on false");

  property p_flags;
    @(posedge clk) disable iff (!rst_n) is_cmov |-> !flags_we;
  endproperty
  a_flags: assert property (p_flags) else $error("flags written");

  property p_ae;
    @(posedge clk) disable iff (!rst_n)
      (issue_valid && op_escape == CMVD_ESCAPE && op_code == CMVD_OP_AE) |-> (do_move == !flag_c);
  endproperty
  a_ae: assert property (p_ae) else $error("ae condition wrong");

  property p_b;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_B) |=> moved_r == $past(flag_c);
  endproperty
  a_b: assert property (p_b) else $error("b condition wrong");

  property p_e;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_E) |-> (do_move == flag_z);
  endproperty
  a_e: assert property (p_e) else $error("e condition wrong");

  property p_ne;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_NE) |-> (do_move == !flag_z);
  endproperty
  a_ne: assert property (p_ne) else $error("ne condition wrong");

  property p_g;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_G) |-> (do_move == (!flag_z && flag_s == flag_o));
  endproperty
  a_g: assert property (p_g) else $error("g condition wrong");

  property p_le;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_LE) |-> (do_move == (flag_z || flag_s != flag_o));
  endproperty
  a_le: assert property (p_le) else $error("le condition wrong");

  property p_l;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_L) |-> (do_move == (flag_s != flag_o));
  endproperty
  a_l: assert property (p_l) else $error("l condition wrong");

  property p_ge;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_GE) |-> (do_move == (flag_s == flag_o));
  endproperty
  a_ge: assert property (p_ge) else $error("ge condition wrong");

  property p_cond;
    @(posedge clk) disable iff (!rst_n)
      (is_cmov && op_code == CMVD_OP_LE) |-> (holds == (flag_z | (flag_s ^ flag_o)));
  endproperty
  a_cond: assert property (p_cond) else $error("condition evaluation wrong");

  property p_mem_src;
    @(posedge clk) disable iff (!rst_n)
      (do_move && f_mod != CMVD_MOD_REG) |=> gpr_r[$past(f_reg)] == $past(mem_data);
  endproperty
  a_mem_src: assert property (p_mem_src) else $error("memory source not moved");

  property p_reg_src;
    @(posedge clk) disable iff (!rst_n)
      (do_move && f_mod == CMVD_MOD_REG) |=> gpr_r[$past(f_reg)] == $past(gpr_r[f_rm]);
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("register source not moved");

  property p_refused;
    @(posedge clk) disable iff (!rst_n) !is_cmov |=> (!done_r && !moved_r);
  endproperty
  a_refused: assert property (p_refused) else $error("done without a cmov");

  property p_moved_done;
    @(posedge clk) disable iff (!rst_n) moved_r |-> done_r;
  endproperty
  a_moved_done: assert property (p_moved_done) else $error("move without done");

  property p_nonfamily;
    @(posedge clk) disable iff (!rst_n)
      (issue_valid && op_escape != CMVD_ESCAPE) |-> !is_cmov;
  endproperty
  a_nonfamily: assert property (p_nonfamily) else $error("wrong escape decoded");
endmodule

// ---- design/cmvd_pkg.sv ----
package cmvd_pkg;
  localparam int          CMVD_DATA_W   = 32;
  localparam int          CMVD_NREG     = 8;
  localparam int          CMVD_RSEL_W   = 3;
  localparam logic [7:0]  CMVD_ESCAPE   = 8'h0f;
  localparam logic [7:0]  CMVD_OP_AE    = 8'h43;
  localparam logic [7:0]  CMVD_OP_B     = 8'h42;
  localparam logic [7:0]  CMVD_OP_E     = 8'h44;
  localparam logic [7:0]  CMVD_OP_NE    = 8'h45;
  localparam logic [7:0]  CMVD_OP_G     = 8'h4f;
  localparam logic [7:0]  CMVD_OP_LE    = 8'h4e;
  localparam logic [7:0]  CMVD_OP_L     = 8'h4c;
  localparam logic [7:0]  CMVD_OP_GE    = 8'h4d;
  localparam logic [1:0]  CMVD_MOD_REG  = 2'h3;
  localparam int          CMVD_MOD_HI   = 7;
  localparam int          CMVD_MOD_LO   = 6;
  localparam int          CMVD_REG_HI   = 5;
  localparam int          CMVD_REG_LO   = 3;
  localparam int          CMVD_RM_HI    = 2;
  localparam int          CMVD_RM_LO    = 0;
  localparam int          CMVD_ISSUE_CLKS = 1;

  typedef enum logic [3:0] {
    CMVD_C_NONE, CMVD_C_AE, CMVD_C_B, CMVD_C_E, CMVD_C_NE,
    CMVD_C_G, CMVD_C_LE, CMVD_C_L, CMVD_C_GE
  } cmvd_cond_t;
endpackage

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  import cmvd_pkg::*;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        issue_valid = 1'b0;
  logic [7:0]  op_escape   = 8'h00;
  logic [7:0]  op_code     = 8'h00;
  logic [7:0]  op_modrm    = 8'h00;
  logic [31:0] mem_data    = 32'h0;
  logic [3:0]  flags       = 4'h0;
  logic [2:0]  gpr_rd_sel  = 3'h0;
  logic [31:0] gpr_rd_data;
  logic        is_cmov;
  logic        done_r;
  logic        moved_r;
  logic        flags_we;
  logic [31:0] shadow [8];
  logic        q_mv [$];
  logic [31:0] q_val [$];
  longint      q_t [$];
  logic        exp_fam     = 1'b0;
  logic        expd;
  logic [2:0]  last_dest   = 3'h0;
  int          miscompares = 0;
  int          checks      = 0;
  localparam int LAT_NS    = CMVD_ISSUE_CLKS * 8 + 4;   // answer edge plus half a period
  logic [7:0]  ops [10]    = '{CMVD_OP_AE, CMVD_OP_B, CMVD_OP_E, CMVD_OP_NE, CMVD_OP_G,
                               CMVD_OP_LE, CMVD_OP_L, CMVD_OP_GE, 8'h46, 8'h47};

  always #4 clk = ~clk;

  cmvd_decode i_dut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .op_escape(op_escape), .op_code(op_code), .op_modrm(op_modrm), .mem_data(mem_data),
    .flag_c(flags[3]), .flag_z(flags[2]), .flag_s(flags[1]), .flag_o(flags[0]),
    .gpr_rd_data(gpr_rd_data), .gpr_rd_sel(gpr_rd_sel), .is_cmov(is_cmov),
    .done_r(done_r), .moved_r(moved_r), .flags_we(flags_we));

  function automatic logic cond_ok(input logic [7:0] op, input logic [3:0] f);
    logic lt;
    lt = f[1] ^ f[0];
    case (op)
      CMVD_OP_AE: return !f[3];
      CMVD_OP_B:  return f[3];
      CMVD_OP_E:  return f[2];
      CMVD_OP_NE: return !f[2];
      CMVD_OP_G:  return !(f[2] | lt);
      CMVD_OP_LE: return f[2] | lt;
      CMVD_OP_L:  return lt;
      default:    return !lt;
    endcase
  endfunction

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // drive one slot and note what must follow
  task issue(input logic v, input logic [7:0] esc, input logic [7:0] op,
             input logic [7:0] mr, input logic [31:0] mem, input logic [3:0] f);
    logic        fam;
    logic        mv;
    logic [31:0] src;
    @(posedge clk);
    fam = v && esc == CMVD_ESCAPE && op inside {CMVD_OP_AE, CMVD_OP_B, CMVD_OP_E, CMVD_OP_NE,
                                                CMVD_OP_G, CMVD_OP_LE, CMVD_OP_L, CMVD_OP_GE};
    src = (mr[7:6] == CMVD_MOD_REG) ? shadow[mr[2:0]] : mem;
    mv = fam && cond_ok(op, f);
    issue_valid <= v;
    op_escape <= esc;
    op_code <= op;
    op_modrm <= mr;
    mem_data <= mem;
    flags <= f;
    gpr_rd_sel <= last_dest;
    exp_fam = fam;
    if (fam) begin
      q_mv.push_back(mv);
      q_val.push_back(mv ? src : shadow[mr[5:3]]);
      q_t.push_back($time);
      if (mv) shadow[mr[5:3]] = src;
      last_dest = mr[5:3];
    end
  endtask

  // output watcher
  always @(negedge clk) begin
    if (rst_n) begin
      chk_bit(is_cmov, exp_fam);
      chk_bit(flags_we, 1'b0);
      expd = q_t.size() != 0 && $time - q_t[0] == LAT_NS;
      chk_bit(done_r, expd);
      if (expd) begin
        chk_bit(moved_r, q_mv.pop_front());
        chk_word(gpr_rd_data, q_val.pop_front());
        void'(q_t.pop_front());
      end else begin
        chk_bit(moved_r, 1'b0);
      end
    end
  end

  task end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // carry clear fails 0f 42: every register must still read zero
  task zero_check;
    int k;
    for (k = 0; k < 8; k++) begin
      issue(1'b1, CMVD_ESCAPE, CMVD_OP_B, {5'(k), 3'h0}, $urandom(), 4'h0);
    end
  endtask

  task rand_burst(input int n);
    repeat (n) begin
      issue($urandom_range(0, 7) != 0, ($urandom_range(0, 7) == 0) ? 8'h0e : CMVD_ESCAPE,
            ops[$urandom_range(0, 9)], 8'($urandom()), $urandom(), 4'($urandom()));
    end
  endtask

  // idle slot, then bounded wait for the last answers
  task drain;
    int k;
    issue(1'b0, 8'h00, 8'h00, 8'h00, 32'h0, 4'h0);
    for (k = 0; k < 20 && q_t.size() != 0; k++) @(posedge clk);
    if (q_t.size() != 0) miscompares++;
  endtask

  initial begin
    int i;
    void'($urandom(39));
    for (i = 0; i < 8; i++) shadow[i] = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    zero_check();
    // load every register from memory, carry clear
    for (i = 0; i < 8; i++) issue(1'b1, CMVD_ESCAPE, CMVD_OP_AE, {5'(i), 3'h0}, $urandom(), 4'h0);
    rand_burst(600);
    drain();
    if (q_t.size() == 0) begin
      // reset again mid-run, registers must clear
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 8; i++) shadow[i] = 32'h0;
      zero_check();
      rand_burst(60);
      drain();
    end
    end_sim();
  end
endmodule
